// ### logic/bsm_pkg.sv
// constants, field layouts and carrier types for the bus selector maintenance logic
// Overview of operation
// [R1] power sequencing holds all control flops reset
// [R2] maintenance-address init: issuer on/routed, other off
// [R3] other-address init clears transfer request only
// [R4] only a side's channel, or either side's maintenance init, alters its flops
// [R5] own or maintenance address enables maintenance responses
// [R6] interrupt ack answered only with maintenance address
// [R7] control pulse with own address, bit zero
// [R8] sync and not-busy confirm every selector instruction
// [R9] bit zero blocks control pulse to peripheral
// [R10] decode seven control pulse codes on bits 4..0
// [R11] recognised code drives error response active
// [R12] status request returns status word in maintenance
// [R13] status word bit layout fixed
// [R14] address field holds wired 3-of-6 code
// [R15] status bits sent inverted, address bits true
// [R16] write captures 18-bit word, read returns it
// [R17] loopback write or read clears transfer request
// [R18] maintenance interrupt ack answers all ones
// [R19] interrupt request command gives single pulse
// [R20] transfer request held until write, read, init
// [R21] maintenance blocks peripheral, normal passes through
// [R22] per side on/off and routing flip-flops
// [R23] unknown control code changes nothing, no error
package bsm_pkg;

  // ************************************************************
  // sizes and addresses
  // ************************************************************
  localparam int ADDR_W = 6;
  localparam int INFO_W = 18;
  localparam int DATA_W = 16;
  localparam int CODE_W = 5;
  localparam logic [ADDR_W-1:0] MAINT_ADDR = 6'h3c;

  // ************************************************************
  // control pulse codes on info leads 4..0
  // ************************************************************
  localparam logic [CODE_W-1:0] CP_NOP = 5'h01;
  localparam logic [CODE_W-1:0] CP_ROUTE_CLR = 5'h07;
  localparam logic [CODE_W-1:0] CP_ROUTE_SET = 5'h0b;
  localparam logic [CODE_W-1:0] CP_SW_OFF = 5'h0d;
  localparam logic [CODE_W-1:0] CP_SW_ON = 5'h13;
  localparam logic [CODE_W-1:0] CP_XFER_SET = 5'h15;
  localparam logic [CODE_W-1:0] CP_INTR = 5'h19;

  // ************************************************************
  // status word field positions
  // ************************************************************
  localparam int ST_OTHER_REQ = 15;
  localparam int ST_OWN_REQ = 14;
  localparam int ST_DEV_INTR = 13;
  localparam int ST_DEV_REQ = 12;
  localparam int ST_OTHER_ON = 11;
  localparam int ST_OWN_ON = 10;
  localparam int ST_OTHER_ROUTE = 9;
  localparam int ST_OWN_ROUTE = 8;
  localparam int ST_OTHER_CHK = 7;
  localparam int ST_OWN_CHK = 6;
  localparam int ST_ADDR_LSB = 0;
  localparam logic [1:0] ST_PARITY = 2'h0;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic ROUTE_RST = 1'b0;
  localparam logic ON_RST = 1'b0;
  localparam logic XFER_RST = 1'b0;
  localparam logic [INFO_W-1:0] LOOP_RST = 18'h00000;
  localparam logic [INFO_W-1:0] ALL_ONES = 18'h3ffff;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int RESP_NS = 200;
  localparam int RESP_CYC = (RESP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLKCHK_NS = 2000;
  localparam int CLKCHK_CYC = (CLKCHK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;

  // ************************************************************
  // carrier types
  // ************************************************************
  typedef enum logic {RSP_IDLE, RSP_DRIVE} bsm_rsp_e;

  typedef struct packed {
    logic init_cmd;
    logic write_data_cmd;
    logic read_data_cmd;
    logic status_request_cmd;
    logic control_pulse_cmd;
    logic interrupt_ack_cmd;
  } bsm_ctrl_s;

  typedef struct packed {
    logic link_clk;
    bsm_ctrl_s ctrl;
    logic [ADDR_W-1:0] adr;
    logic [INFO_W-1:0] info_leads;
  } bsm_bus_in_s;

  typedef struct packed {
    logic [INFO_W-1:0] info_leads;
    logic info_oe;
    logic sync_response;
    logic not_busy_response;
    logic error_response;
    logic interrupt_line;
    logic transfer_request_line;
  } bsm_bus_out_s;

  typedef struct packed {
    logic valid;
    bsm_ctrl_s ctrl;
    logic [ADDR_W-1:0] adr;
    logic [INFO_W-1:0] info_leads;
  } bsm_cmd_s;

endpackage

// ### logic/bsm_selector.sv
// duplex bus selector control state, maintenance commands and responses
`timescale 1ns/1ps
module bsm_selector (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic bus_driver_supply,
  input wire logic [bsm_pkg::ADDR_W-1:0] own_bin_addr,
  input wire logic [bsm_pkg::ADDR_W-1:0] own_code_addr,
  input wire logic dev_interrupt,
  input wire logic dev_request,
  input wire bsm_pkg::bsm_bus_in_s [1:0] bus_in,
  output bsm_pkg::bsm_bus_out_s [1:0] bus_out,
  output logic [1:0] periph_enable,
  output logic [1:0] cp_to_periph
);
  import bsm_pkg::*;

  localparam int PW = 2 * ADDR_W + 3;

  // ************************************************************
  // declarations
  // ************************************************************
  logic [PW-1:0] pin_meta_r;
  logic [PW-1:0] pin_sync_r;
  logic [ADDR_W-1:0] bin_addr;
  logic [ADDR_W-1:0] code_addr;
  logic supply_ok;
  logic dev_intr_s;
  logic dev_req_s;

  bsm_cmd_s cmd [2];
  logic [1:0] link_edge;

  logic [1:0] route_r;
  logic [1:0] on_r;
  logic [1:0] xfer_r;
  logic [INFO_W-1:0] loop_r;
  logic [CNT_W-1:0] chk_cnt_r [2];
  logic [1:0] chk_ok;

  logic [1:0] maint;
  logic [1:0] normal;
  logic [1:0] hit_own;
  logic [1:0] hit_maint;
  logic [1:0] do_wr;
  logic [1:0] do_rd;
  logic [1:0] do_st;
  logic [1:0] do_ack;
  logic [1:0] do_cp;
  logic [1:0] init_m;
  logic [1:0] init_o;
  logic [1:0] cp_valid;
  logic [1:0] answer;
  logic [CODE_W-1:0] code [2];
  logic [DATA_W-1:0] status_word [2];

  bsm_rsp_e rsp_state_r [2];
  logic [CNT_W-1:0] rsp_cnt_r [2];
  bsm_bus_out_s [1:0] out_r;
  logic [1:0] pen_r;
  logic [1:0] cpf_r;

  // ************************************************************
  // wired straps and peripheral levels
  // ************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else begin
      pin_meta_r <= {bus_driver_supply, dev_interrupt, dev_request, own_bin_addr, own_code_addr};
      pin_sync_r <= pin_meta_r;
    end
  end

  assign supply_ok = pin_sync_r[PW-1];
  assign dev_intr_s = pin_sync_r[PW-2];
  assign dev_req_s = pin_sync_r[PW-3];
  assign bin_addr = pin_sync_r[2*ADDR_W-1:ADDR_W];
  assign code_addr = pin_sync_r[ADDR_W-1:0];

  // ************************************************************
  // bus side receivers
  // ************************************************************
  for (genvar s = 0; s < 2; s++) begin : g_side
    bsm_side_rx u_rx (
      .clk(clk),
      .rst_b(rst_b),
      .bus_in(bus_in[s]),
      .cmd(cmd[s]),
      .link_edge(link_edge[s])
    );
  end

  // ************************************************************
  // command decode
  // ************************************************************
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      maint[s] = on_r[s] & ~route_r[s];
      normal[s] = on_r[s] & route_r[s];
      hit_own[s] = cmd[s].adr == bin_addr;
      hit_maint[s] = cmd[s].adr == MAINT_ADDR;
      code[s] = cmd[s].info_leads[CODE_W-1:0];
      do_wr[s] = cmd[s].valid & cmd[s].ctrl.write_data_cmd & maint[s]
                 & (hit_own[s] | hit_maint[s]); // R5
      do_rd[s] = cmd[s].valid & cmd[s].ctrl.read_data_cmd & maint[s]
                 & (hit_own[s] | hit_maint[s]); // R5
      do_st[s] = cmd[s].valid & cmd[s].ctrl.status_request_cmd & maint[s]
                 & (hit_own[s] | hit_maint[s]); // R5
      do_ack[s] = cmd[s].valid & cmd[s].ctrl.interrupt_ack_cmd & maint[s] & hit_maint[s]; // R6
      do_cp[s] = cmd[s].valid & cmd[s].ctrl.control_pulse_cmd & on_r[s] & hit_own[s]
                 & cmd[s].info_leads[0]; // R7
      init_m[s] = cmd[s].valid & cmd[s].ctrl.init_cmd & hit_maint[s];
      init_o[s] = cmd[s].valid & cmd[s].ctrl.init_cmd & ~hit_maint[s];
      case (code[s]) // R10
        CP_NOP, CP_ROUTE_CLR, CP_ROUTE_SET, CP_SW_OFF,
        CP_SW_ON, CP_XFER_SET, CP_INTR: cp_valid[s] = do_cp[s];
        default: cp_valid[s] = 1'b0; // R23
      endcase
      answer[s] = do_wr[s] | do_rd[s] | do_st[s] | do_ack[s] | do_cp[s] | init_m[s];
    end
  end

  // ************************************************************
  // side control flip-flops
  // ************************************************************
  // the supply level acts as a synchronous hold so that a dropping supply
  // cannot leave a side half switched
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      route_r <= {2{ROUTE_RST}};
      on_r <= {2{ON_RST}};
    end else if (!supply_ok) begin
      route_r <= {2{ROUTE_RST}}; // R1
      on_r <= {2{ON_RST}}; // R1
    end else if (|init_m) begin
      // side zero wins when both channels initialise on the same edge
      route_r <= init_m[0] ? 2'h1 : 2'h2; // R2
      on_r <= init_m[0] ? 2'h1 : 2'h2; // R2
    end else begin
      for (int s = 0; s < 2; s++) begin
        if (cp_valid[s]) begin // R4
          case (code[s])
            CP_ROUTE_CLR: route_r[s] <= 1'b0; // R22
            CP_ROUTE_SET: route_r[s] <= 1'b1; // R22
            CP_SW_OFF: on_r[s] <= 1'b0; // R22
            CP_SW_ON: on_r[s] <= 1'b1; // R22
            default: route_r[s] <= route_r[s];
          endcase
        end
      end
    end
  end

  // ************************************************************
  // transfer request flip-flops
  // ************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      xfer_r <= {2{XFER_RST}};
    end else if (!supply_ok) begin
      xfer_r <= {2{XFER_RST}}; // R1
    end else begin
      for (int s = 0; s < 2; s++) begin
        if (cp_valid[s] && code[s] == CP_XFER_SET) begin
          xfer_r[s] <= 1'b1; // R20
        end else if (do_wr[s] || do_rd[s]) begin
          xfer_r[s] <= 1'b0; // R17
        end else if (init_m[s] || init_o[s]) begin
          xfer_r[s] <= 1'b0; // R3
        end
      end
    end
  end

  // ************************************************************
  // loopback register
  // ************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      loop_r <= LOOP_RST;
    end else if (do_wr[0]) begin
      loop_r <= cmd[0].info_leads; // R16
    end else if (do_wr[1]) begin
      loop_r <= cmd[1].info_leads; // R16
    end
  end

  // ************************************************************
  // link clock check
  // ************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chk_cnt_r[0] <= '0;
      chk_cnt_r[1] <= '0;
    end else begin
      for (int s = 0; s < 2; s++) begin
        if (link_edge[s]) begin
          chk_cnt_r[s] <= '0;
        end else if (chk_cnt_r[s] < CNT_W'(CLKCHK_CYC)) begin
          chk_cnt_r[s] <= chk_cnt_r[s] + 1'b1;
        end
      end
    end
  end

  assign chk_ok[0] = chk_cnt_r[0] < CNT_W'(CLKCHK_CYC);
  assign chk_ok[1] = chk_cnt_r[1] < CNT_W'(CLKCHK_CYC);

  // ************************************************************
  // status word, own side view
  // ************************************************************
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      status_word[s] = '0;
      status_word[s][ST_OTHER_REQ] = xfer_r[1-s]; // R13
      status_word[s][ST_OWN_REQ] = xfer_r[s];
      status_word[s][ST_DEV_INTR] = dev_intr_s;
      status_word[s][ST_DEV_REQ] = dev_req_s;
      status_word[s][ST_OTHER_ON] = on_r[1-s];
      status_word[s][ST_OWN_ON] = on_r[s];
      status_word[s][ST_OTHER_ROUTE] = route_r[1-s];
      status_word[s][ST_OWN_ROUTE] = route_r[s];
      status_word[s][ST_OTHER_CHK] = chk_ok[1-s];
      status_word[s][ST_OWN_CHK] = chk_ok[s];
      status_word[s][ST_ADDR_LSB+:ADDR_W] = code_addr; // R14
    end
  end

  // ************************************************************
  // responses
  // ************************************************************
  // one response window per side; a new instruction inside the window
  // reloads it, the channel is expected to wait for sync first
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rsp_state_r[0] <= RSP_IDLE;
      rsp_state_r[1] <= RSP_IDLE;
      rsp_cnt_r[0] <= '0;
      rsp_cnt_r[1] <= '0;
      out_r <= '0;
    end else begin
      for (int s = 0; s < 2; s++) begin
        out_r[s].transfer_request_line <= xfer_r[s]; // R20
        if (answer[s] && supply_ok) begin
          rsp_state_r[s] <= RSP_DRIVE;
          rsp_cnt_r[s] <= CNT_W'(RESP_CYC - 1);
          out_r[s].sync_response <= 1'b1; // R8
          out_r[s].not_busy_response <= 1'b1; // R8
          out_r[s].error_response <= cp_valid[s]; // R11
          out_r[s].interrupt_line <= cp_valid[s] & (code[s] == CP_INTR); // R19
          out_r[s].info_oe <= do_rd[s] | do_st[s] | do_ack[s];
          if (do_ack[s]) begin
            out_r[s].info_leads <= ALL_ONES; // R18
          end else if (do_st[s]) begin
            out_r[s].info_leads <= {ST_PARITY,
                                    ~status_word[s][DATA_W-1:ADDR_W],
                                    status_word[s][ADDR_W-1:0]}; // R12 R15
          end else if (do_rd[s]) begin
            out_r[s].info_leads <= loop_r; // R16
          end else begin
            out_r[s].info_leads <= '0;
          end
        end else begin
          case (rsp_state_r[s])
            RSP_DRIVE: begin
              if (rsp_cnt_r[s] == '0) begin
                rsp_state_r[s] <= RSP_IDLE;
                out_r[s].sync_response <= 1'b0;
                out_r[s].not_busy_response <= 1'b0;
                out_r[s].error_response <= 1'b0;
                out_r[s].interrupt_line <= 1'b0;
                out_r[s].info_oe <= 1'b0;
                out_r[s].info_leads <= '0;
              end else begin
                rsp_cnt_r[s] <= rsp_cnt_r[s] - 1'b1;
              end
            end
            default: rsp_state_r[s] <= RSP_IDLE;
          endcase
        end
      end
    end
  end

  // ************************************************************
  // peripheral side gating
  // ************************************************************
  // maintenance and out-of-service sides never reach the peripheral, so the
  // selector ends the bus there
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pen_r <= 2'h0;
      cpf_r <= 2'h0;
    end else begin
      for (int s = 0; s < 2; s++) begin
        pen_r[s] <= normal[s] & supply_ok; // R21
        cpf_r[s] <= cmd[s].valid & cmd[s].ctrl.control_pulse_cmd & normal[s]
                    & ~cmd[s].info_leads[0] & supply_ok; // R9 R21
      end
    end
  end

  assign bus_out = out_r;
  assign periph_enable = pen_r;
  assign cp_to_periph = cpf_r;

endmodule // bsm_selector

// ### logic/bsm_side_rx.sv
// one bus side: input synchroniser, link clock edge finder and command capture
`timescale 1ns/1ps
module bsm_side_rx (
  input wire logic clk,
  input wire logic rst_b,
  input wire bsm_pkg::bsm_bus_in_s bus_in,
  output bsm_pkg::bsm_cmd_s cmd,
  output logic link_edge
);
  import bsm_pkg::*;

  localparam int SW = $bits(bsm_bus_in_s);

  logic [SW-1:0] meta_r;
  logic [SW-1:0] sync_r;
  logic clk_prev_r;
  bsm_bus_in_s cur;
  bsm_cmd_s cmd_r;
  logic edge_r;

  assign cur = bsm_bus_in_s'(sync_r);

  // ************************************************************
  // two-stage synchroniser
  // ************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= bus_in;
      sync_r <= meta_r;
    end
  end

  // ************************************************************
  // capture on rising link clock edge
  // ************************************************************
  // leads are skewed equally through the synchroniser, so sampling them
  // together with the synchronised clock keeps their relation
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_prev_r <= 1'b0;
      edge_r <= 1'b0;
      cmd_r <= '0;
    end else begin
      clk_prev_r <= cur.link_clk;
      edge_r <= cur.link_clk & ~clk_prev_r;
      cmd_r.valid <= cur.link_clk & ~clk_prev_r & (|cur.ctrl);
      cmd_r.ctrl <= cur.ctrl;
      cmd_r.adr <= cur.adr;
      cmd_r.info_leads <= cur.info_leads;
    end
  end

  assign cmd = cmd_r;
  assign link_edge = edge_r;

endmodule // bsm_side_rx

// ### verification/bsm_channel_model.sv
// channel controller model: frames one command at a time on one selector side
`timescale 1ns/1ps
module bsm_channel_model (
  input wire logic clk,
  input wire bsm_pkg::bsm_bus_out_s bus_out,
  output bsm_pkg::bsm_bus_in_s bus_in
);
  import bsm_pkg::*;
  logic link_r = 1'b0;
  bsm_ctrl_s ctrl_r = '0;
  logic [ADDR_W-1:0] adr_r = 6'h00;
  logic [INFO_W-1:0] drv_r = 18'h00000;
  // info leads are wired-or: a one from either end wins
  assign bus_in = {link_r, ctrl_r, adr_r, drv_r | (bus_out.info_oe ? bus_out.info_leads : drv_r)};
  // ****
  // one framed command; link clock stands still between frames
  // ****
  task automatic issue(input bsm_ctrl_s c, input logic [ADDR_W-1:0] a,
                       input logic [INFO_W-1:0] d, output bsm_bus_out_s r);
    int n;
    r = '0;
    n = 0;
    @(posedge clk);
    ctrl_r <= c;
    adr_r <= a;
    drv_r <= d;
    repeat (4) @(posedge clk);
    // one link clock pulse: high for four system clocks (100 ns), then low
    link_r <= 1'b1;
    repeat (4) @(posedge clk);
    link_r <= 1'b0;
    @(negedge clk);
    while (bus_out.sync_response !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    if (bus_out.sync_response === 1'b1) r = bus_out;
    repeat (4) @(posedge clk);
    // released leads carry no stale copy of the request
    ctrl_r <= '0;
    adr_r <= ~a;
    drv_r <= ~d;
    repeat (10) @(posedge clk);
  endtask
endmodule // bsm_channel_model

// ### verification/bsm_selector_sva.sv
// concurrent checks on the selector top ports
`timescale 1ns/1ps
module bsm_selector_sva (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic bus_driver_supply,
  input wire bsm_pkg::bsm_bus_in_s [1:0] bus_in,
  input wire bsm_pkg::bsm_bus_out_s [1:0] bus_out,
  input wire logic [1:0] periph_enable,
  input wire logic [1:0] cp_to_periph
);
  import bsm_pkg::*;
  logic [4:0] age_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ****
  // age of the last clear cause on side 0
  // ****
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      age_r <= 5'h1f;
    end else if (!bus_driver_supply || bus_in[0].ctrl.init_cmd || bus_in[0].ctrl.write_data_cmd
                 || bus_in[0].ctrl.read_data_cmd) begin
      age_r <= 5'h00;
    end else if (age_r != 5'h1f) begin
      age_r <= age_r + 5'h01;
    end
  end
  sequence answer_s;
    bus_out[0].sync_response && bus_out[0].not_busy_response;
  endsequence
  sequence intr_s;
    bus_out[0].interrupt_line && bus_out[0].error_response;
  endsequence
  // ****
  // assertions
  // ****
  supply_clear_a: assert property ((!bus_driver_supply) [*6] |-> periph_enable == 2'h0
    && !bus_out[0].transfer_request_line && !bus_out[1].transfer_request_line)
    else $error("control flops not cleared while unpowered");
  answer_hold_a: assert property ($rose(bus_out[0].sync_response) |-> answer_s [*8])
    else $error("sync or not busy dropped early");
  answer_pair_a: assert property (bus_out[1].sync_response == bus_out[1].not_busy_response)
    else $error("side 1 sync and not busy differ");
  intr_pulse_a: assert property ($rose(bus_out[0].interrupt_line) |->
    intr_s [*8] ##1 !bus_out[0].interrupt_line)
    else $error("interrupt pulse malformed");
  info_window_a: assert property (bus_out[0].info_oe |-> bus_out[0].sync_response)
    else $error("info leads driven outside an answer");
  cp_single_a: assert property (cp_to_periph[0] |=> !cp_to_periph[0])
    else $error("forwarded control pulse too long");
  cp_normal_a: assert property (cp_to_periph[0] |->
    periph_enable[0] && !$past(bus_in[0].info_leads[0], 4))
    else $error("control pulse forwarded wrongly");
  one_owner_a: assert property (periph_enable != 2'h3)
    else $error("both sides own the peripheral");
  xfer_hold_a: assert property ($fell(bus_out[0].transfer_request_line) |->
    age_r < 5'h0c)
    else $error("transfer request dropped without a clear");
endmodule // bsm_selector_sva

// ### verification/duplex_bus_selector_maintenance_tb.sv
// bench: channel models on both sides exercise the selector maintenance logic
`timescale 1ns/1ps
module duplex_bus_selector_maintenance_tb;
  import bsm_pkg::*;
  localparam logic [ADDR_W-1:0] BIN = 6'h05;
  localparam logic [ADDR_W-1:0] CODE = 6'h0b;
  localparam logic [ADDR_W-1:0] FOE = 6'h11;
  localparam logic [5:0] INIT = 6'h20;
  localparam logic [5:0] WR = 6'h10;
  localparam logic [5:0] RD = 6'h08;
  localparam logic [5:0] ST = 6'h04;
  localparam logic [5:0] CP = 6'h02;
  localparam logic [5:0] ACK = 6'h01;
  localparam logic [INFO_W-1:0] Z = 18'h00000;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic bus_driver_supply = 1'b1;
  logic dev_interrupt = 1'b1;
  logic dev_request = 1'b0;
  wire bsm_bus_in_s [1:0] bus_in;
  bsm_bus_out_s [1:0] bus_out;
  logic [1:0] periph_enable;
  logic [1:0] cp_to_periph;
  bsm_bus_out_s r;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  int cp_count = 0;
  int cp_count1 = 0;
  int cp_base = 0;
  logic [CODE_W-1:0] codes [7] = '{CP_NOP, CP_INTR, 5'h03, 5'h1f,
                                    CP_ROUTE_SET, CP_ROUTE_CLR, CP_SW_ON};
  logic errs [7] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  logic pes [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  logic [INFO_W-1:0] words [2] = '{18'h2a5c3, 18'h15a3c};
  bsm_selector dut (.clk(clk), .rst_b(rst_b), .bus_driver_supply(bus_driver_supply),
    .own_bin_addr(BIN), .own_code_addr(CODE), .dev_interrupt(dev_interrupt),
    .dev_request(dev_request), .bus_in(bus_in), .bus_out(bus_out),
    .periph_enable(periph_enable), .cp_to_periph(cp_to_periph));
  bsm_channel_model ch0 (.clk(clk), .bus_out(bus_out[0]), .bus_in(bus_in[0]));
  bsm_channel_model ch1 (.clk(clk), .bus_out(bus_out[1]), .bus_in(bus_in[1]));
  always #12.5 clk = ~clk;
  // run takes about 1000 cycles; the ceiling leaves ample margin
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cp_to_periph[0] === 1'b1) cp_count <= cp_count + 1;
    if (cp_to_periph[1] === 1'b1) cp_count1 <= cp_count1 + 1;
    if (cycles == 6000) begin
      failures = failures + 1;
      conclude();
    end
  end
  task automatic conclude();
    if (failures == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [INFO_W-1:0] seen,
                       input logic [INFO_W-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic flag(input string what, input logic seen, input logic exp);
    check(what, {17'h00000, seen}, {17'h00000, exp});
  endtask
  task automatic cmd(input bit s, input logic [5:0] op, input logic [ADDR_W-1:0] a,
                     input logic [INFO_W-1:0] d);
    if (s) ch1.issue(bsm_ctrl_s'(op), a, d, r);
    else ch0.issue(bsm_ctrl_s'(op), a, d, r);
  endtask
  task automatic refused(input bit s, input logic [5:0] op, input logic [ADDR_W-1:0] a);
    cmd(s, op, a, 18'(CP_NOP));
    flag("no answer", r.sync_response, 1'b0);
  endtask
  // other side's clock check is masked: it depends on when that side last framed
  task automatic stat(input bit s, input logic mreq);
    cmd(s, ST, BIN, Z);
    check("status", r.info_leads & 18'h3ff7f, {2'h0, 1'b1, ~mreq, ~dev_interrupt,
          ~dev_request, 1'b1, 1'b0, 1'b1, 1'b1, 2'h0, CODE});
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    check("modes after reset", 18'(periph_enable), Z);
    refused(1'b0, ST, BIN);
    cmd(1'b0, INIT, MAINT_ADDR, Z);
    flag("init sync", r.sync_response & r.not_busy_response, 1'b1);
    check("init modes", 18'(periph_enable), 18'h00001);
    cp_base = cp_count;
    cmd(1'b0, CP, FOE, 18'h00010);
    check("cp passed", 18'(cp_count - cp_base), 18'h00001);
    cmd(1'b0, CP, BIN, 18'(CP_ROUTE_CLR));
    check("maint blocks", 18'(periph_enable), Z);
    cp_base = cp_count;
    for (int i = 0; i < 7; i++) begin
      cmd(1'b0, CP, BIN, 18'(codes[i]));
      flag("cp sync", r.sync_response, 1'b1);
      flag("cp error", r.error_response, errs[i]);
      flag("cp intr", r.interrupt_line, codes[i] == CP_INTR);
      flag("cp mode", periph_enable[0], pes[i]);
    end
    check("cp blocked", 18'(cp_count - cp_base), Z);
    refused(1'b0, CP, FOE);
    stat(1'b0, 1'b0);
    cmd(1'b0, ST, MAINT_ADDR, Z);
    flag("shared addr status", r.info_oe, 1'b1);
    refused(1'b0, ST, FOE);
    cmd(1'b0, CP, BIN, 18'(CP_XFER_SET));
    flag("xfer set", bus_out[0].transfer_request_line, 1'b1);
    stat(1'b0, 1'b1);
    flag("xfer held", bus_out[0].transfer_request_line, 1'b1);
    for (int i = 0; i < 2; i++) begin
      cmd(1'b0, WR, BIN, words[i]);
      flag("xfer after write", bus_out[0].transfer_request_line, 1'b0);
      cmd(1'b0, CP, BIN, 18'(CP_XFER_SET));
      cmd(1'b0, RD, BIN, Z);
      check("loopback", r.info_leads, words[i]);
      flag("xfer after read", bus_out[0].transfer_request_line, 1'b0);
    end
    cmd(1'b0, CP, BIN, 18'(CP_XFER_SET));
    cmd(1'b0, INIT, FOE, Z);
    flag("xfer after init", bus_out[0].transfer_request_line, 1'b0);
    stat(1'b0, 1'b0);
    cmd(1'b0, ACK, MAINT_ADDR, Z);
    check("ack word", r.info_leads, ALL_ONES);
    refused(1'b0, ACK, BIN);
    cmd(1'b1, CP, BIN, 18'(CP_SW_OFF));
    flag("other side cp", r.sync_response, 1'b0);
    stat(1'b0, 1'b0);
    cmd(1'b0, CP, BIN, 18'(CP_SW_OFF));
    flag("off error", r.error_response, 1'b1);
    refused(1'b0, ST, BIN);
    cmd(1'b1, INIT, MAINT_ADDR, Z);
    check("side 1 init", 18'(periph_enable), 18'h00002);
    cp_base = cp_count1;
    cmd(1'b1, CP, FOE, 18'h00010);
    check("side 1 cp passed", 18'(cp_count1 - cp_base), 18'h00001);
    cmd(1'b1, CP, BIN, 18'(CP_ROUTE_CLR));
    stat(1'b1, 1'b0);
    cmd(1'b1, CP, BIN, 18'(CP_XFER_SET));
    flag("side 1 xfer set", bus_out[1].transfer_request_line, 1'b1);
    bus_driver_supply <= 1'b0;
    refused(1'b1, ST, BIN);
    check("unpowered", {16'h0000, bus_out[1].transfer_request_line, periph_enable[1]}, Z);
    bus_driver_supply <= 1'b1;
    refused(1'b1, ST, BIN);
    conclude();
  end
endmodule // duplex_bus_selector_maintenance_tb
bind bsm_selector bsm_selector_sva chk (.clk(clk), .rst_b(rst_b),
  .bus_driver_supply(bus_driver_supply), .bus_in(bus_in), .bus_out(bus_out),
  .periph_enable(periph_enable), .cp_to_periph(cp_to_periph));
